// *** hw/tpsr_defs.svh ***
// tpsr_defs.svh: offsets, field positions, reset values and timing figures of the touch packet reporter
// assumes a single 250 MHz clock; included by bare name from the design files
`ifndef TPSR_DEFS_SVH
`define TPSR_DEFS_SVH

`define TPSR_CLK_HZ          250000000
`define TPSR_PKT_RATE_HZ     192
`define TPSR_FULL_PERIOD_S   1
`define TPSR_SUSPEND_S       3
`define TPSR_ALIGN_HOLD_MS   500
`define TPSR_PKT_CYCLES      (`TPSR_CLK_HZ / `TPSR_PKT_RATE_HZ)
`define TPSR_FULL_CYCLES     (`TPSR_CLK_HZ * `TPSR_FULL_PERIOD_S)
`define TPSR_SUSPEND_CYCLES  (`TPSR_CLK_HZ * `TPSR_SUSPEND_S)
`define TPSR_HOLD_CYCLES     ((`TPSR_CLK_HZ / 1000) * `TPSR_ALIGN_HOLD_MS)

`define TPSR_REG_CTRL        4'h0
`define TPSR_REG_STATUS      4'h4
`define TPSR_REG_POINT       4'h8
`define TPSR_CTRL_BAUD_BIT   0
`define TPSR_CTRL_COMP_BIT   1
`define TPSR_CTRL_RESET      2'h2

`define TPSR_PKT_BYTES       5
`define TPSR_LAST_IDX        3'h4
`define TPSR_MARK_BIT        7
`define TPSR_LIFT_BIT        6
`define TPSR_RES_BIT         5
`define TPSR_CHAR_ALIGN      8'h4B
`define TPSR_STAT_FAIL       8'hC0
`define TPSR_STAT_FIRST      8'hC1
`define TPSR_STAT_DONE       8'hC2
`define TPSR_GREET_LEN       4'h9
`define TPSR_MIN_SEP         12'h100

`endif

// *** hw/tpsr_pkg.sv ***
// tpsr_pkg: types shared by the touch packet reporter modules
// assumes nothing beyond the defs header
package tpsr_pkg;
   typedef logic [4:0][7:0] tpsr_pkt_t;
   typedef enum logic [2:0] {
      TPSR_ST_GREET  = 3'h0,
      TPSR_ST_IDLE   = 3'h1,
      TPSR_ST_SEND   = 3'h3,
      TPSR_ST_ALIGN1 = 3'h2,
      TPSR_ST_ALIGN2 = 3'h6,
      TPSR_ST_ASTAT  = 3'h7
   } tpsr_state_t;
endpackage : tpsr_pkg

// *** hw/tpsr_pkt_if.sv ***
// tpsr_pkt_if: carries one touch report to the packet encoder and its bytes back
// assumes both ends sit in the same clock domain
`timescale 1ns/100ps
interface tpsr_pkt_if;
   logic [11:0]         x;
   logic [11:0]         y;
   logic [7:0]          z;
   logic                lift;
   tpsr_pkg::tpsr_pkt_t prev;
   tpsr_pkg::tpsr_pkt_t bytes;
   logic [2:0]          first_diff;
   modport enc (input x, y, z, lift, prev, output bytes, first_diff);
   modport ctl (output x, y, z, lift, prev, input bytes, first_diff);
endinterface : tpsr_pkt_if

// *** hw/tpsr_tick.sv ***
// tpsr_tick: restartable cycle counter giving a one-cycle pulse every CYCLES clocks
// assumes i_restart is synchronous to i_clock
`timescale 1ns/100ps
module tpsr_tick #(
   parameter int unsigned CYCLES = 4
) (
   input  wire logic i_clock,
   input  wire logic i_resetn,
   input  wire logic i_restart,
   output logic      o_tick
);
   localparam int W = $clog2(CYCLES + 1);
   logic [W-1:0] count_q;

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         count_q <= '0;
         o_tick  <= 1'b0;
      end else if (i_restart) begin
         count_q <= '0;
         o_tick  <= 1'b0;
      end else if (count_q == W'(CYCLES - 1)) begin
         count_q <= '0;
         o_tick  <= 1'b1;
      end else begin
         count_q <= count_q + 1'b1;
         o_tick  <= 1'b0;
      end
   end
endmodule : tpsr_tick

// *** hw/tpsr_pkt_enc.sv ***
// tpsr_pkt_enc: packs one report into five bytes and finds the first byte that differs from the last packet
// assumes prev holds the bytes of the packet sent before
`timescale 1ns/100ps
`include "tpsr_defs.svh"
module tpsr_pkt_enc (
   tpsr_pkt_if.enc p
);
   tpsr_pkg::tpsr_pkt_t b;
   logic [2:0]          fd;

   always_comb begin
      b[0] = {1'b0, p.lift, 1'b0, p.y[11:7]};
      b[1] = {1'b0, p.z[7:6], p.x[11:7]};
      b[2] = {1'b0, p.y[6:0]};
      b[3] = {1'b0, p.x[6:0]};
      b[4] = {2'b10, p.z[5:0]};
   end

   // last byte always goes out, so the search stops short of it
   always_comb begin
      fd = `TPSR_LAST_IDX;
      for (int i = 3; i >= 0; i--) begin
         if (b[i] != p.prev[i]) begin
            fd = 3'(i);
         end
      end
   end

   assign p.bytes      = b;
   assign p.first_diff = fd;
endmodule : tpsr_pkt_enc

// *** hw/tpsr_top.sv ***
// tpsr_top: serial report framer of a resistive touch controller, with greeting, packets and alignment
// assumes a uart engine outside consumes tx bytes on valid/ready and delivers rx bytes as pulses
// Notes on behaviour
// - link is 9600 baud, 8N1
// - 19200 baud selectable, same framing
// - greeting text sent before any packet
// - 192 packets per second while touched
// - one zero-pressure packet on lift-off
// - 12-bit x, 12-bit y, 8-bit pressure
// - five bytes, only last has top bit
// - reserved bit zero, lift flag marks lift-off
// - leading unchanged bytes may be skipped
// - first packet full, full one each second
// - skipping is optional, full always conforms
// - K starts alignment, packets halt
// - status C1 then C2 on targets held
// - status C0 when alignment fails
// - any rx byte suspends packets seconds
`timescale 1ns/100ps
`include "tpsr_defs.svh"
module tpsr_top #(
   parameter int unsigned PKT_CYCLES     = `TPSR_PKT_CYCLES,
   parameter int unsigned FULL_CYCLES    = `TPSR_FULL_CYCLES,
   parameter int unsigned SUSPEND_CYCLES = `TPSR_SUSPEND_CYCLES,
   parameter int unsigned HOLD_CYCLES    = `TPSR_HOLD_CYCLES,
   parameter logic [11:0] MIN_SEP        = `TPSR_MIN_SEP
) (
   input  wire logic        i_clock,
   input  wire logic        i_resetn,
   input  wire logic [3:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   output logic      [31:0] o_avs_readdata,
   output logic             o_avs_waitrequest,
   input  wire logic        i_sample_valid,
   input  wire logic        i_touched,
   input  wire logic [11:0] i_x,
   input  wire logic [11:0] i_y,
   input  wire logic [7:0]  i_z,
   input  wire logic        i_rx_valid,
   input  wire logic [7:0]  i_rx_data,
   output logic             o_tx_valid,
   output logic      [7:0]  o_tx_data,
   input  wire logic        i_tx_ready,
   output logic             o_baud_19200
);
   tpsr_pkg::tpsr_state_t state_q;
   tpsr_pkt_if            pif ();
   tpsr_pkg::tpsr_pkt_t   pkt_q;
   tpsr_pkg::tpsr_pkt_t   prev_q;
   logic [2:0]            idx_q;
   logic [3:0]            greet_q;
   logic                  greet_done_q;
   logic                  comp_en_q;
   logic [11:0]           x_q, y_q, ax_q, ay_q;
   logic [7:0]            z_q;
   logic                  touched_q, reported_q, lift_q;
   logic                  full_q, suspend_q, align_req_q, align_fail_q;
   logic                  pkt_tick, full_tick, susp_tick, hold_tick;
   logic                  tx_acc, rx_any, start_pkt, send_lift;
   logic [11:0]           dx, dy;
   logic                  aligning;

   function automatic logic [7:0] greet_char(input logic [3:0] i);
      unique case (i)
         4'h0: greet_char = 8'h48;
         4'h1: greet_char = 8'h65;
         4'h2: greet_char = 8'h6C;
         4'h3: greet_char = 8'h6C;
         4'h4: greet_char = 8'h6F;
         4'h5: greet_char = 8'h20;
         4'h6: greet_char = 8'h50;
         4'h7: greet_char = 8'h6E;
         default: greet_char = 8'h50;
      endcase
   endfunction : greet_char

   function automatic logic [11:0] absdiff(input logic [11:0] a, input logic [11:0] b);
      absdiff = (a > b) ? a - b : b - a;
   endfunction : absdiff

   assign tx_acc    = o_tx_valid && i_tx_ready;
   assign rx_any    = i_rx_valid;
   assign send_lift = !touched_q && reported_q;
   assign start_pkt = (state_q == tpsr_pkg::TPSR_ST_IDLE) && pkt_tick && !suspend_q
                      && !align_req_q && (touched_q || send_lift);
   assign aligning  = (state_q == tpsr_pkg::TPSR_ST_ALIGN1) || (state_q == tpsr_pkg::TPSR_ST_ALIGN2);
   assign dx        = absdiff(ax_q, x_q);
   assign dy        = absdiff(ay_q, y_q);

   assign pif.x    = x_q;
   assign pif.y    = y_q;
   assign pif.z    = send_lift ? 8'h00 : z_q;
   assign pif.lift = send_lift;
   assign pif.prev = prev_q;

   tpsr_pkt_enc u_enc (
      .p (pif.enc)
   );

   tpsr_tick #(.CYCLES(PKT_CYCLES)) u_pkt_tick (
      .i_clock   (i_clock),
      .i_resetn  (i_resetn),
      .i_restart (1'b0),
      .o_tick    (pkt_tick)
   );

   tpsr_tick #(.CYCLES(FULL_CYCLES)) u_full_tick (
      .i_clock   (i_clock),
      .i_resetn  (i_resetn),
      .i_restart (1'b0),
      .o_tick    (full_tick)
   );

   // suspend timer, rearmed by every rx byte
   tpsr_tick #(.CYCLES(SUSPEND_CYCLES)) u_susp_tick (
      .i_clock   (i_clock),
      .i_resetn  (i_resetn),
      .i_restart (rx_any),
      .o_tick    (susp_tick)
   );

   // target hold time, counted only while aligning so a touch before 'K' gives no head start
   // rearmed on release; a held finger needs a fresh full hold per target
   tpsr_tick #(.CYCLES(HOLD_CYCLES)) u_hold_tick (
      .i_clock   (i_clock),
      .i_resetn  (i_resetn),
      .i_restart (!touched_q || o_tx_valid || hold_tick || !aligning),
      .o_tick    (hold_tick)
   );

   // latest touch sample
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         x_q       <= 12'h000;
         y_q       <= 12'h000;
         z_q       <= 8'h00;
         touched_q <= 1'b0;
      end else if (i_sample_valid) begin
         x_q       <= i_x;
         y_q       <= i_y;
         z_q       <= i_z;
         touched_q <= i_touched;
      end
   end

   // suspension flag, set wins over expiry
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         suspend_q <= 1'b0;
      end else if (rx_any) begin
         suspend_q <= 1'b1;
      end else if (susp_tick) begin
         suspend_q <= 1'b0;
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         align_req_q <= 1'b0;
      end else if (rx_any && i_rx_data == `TPSR_CHAR_ALIGN) begin
         align_req_q <= 1'b1;
      end else if (state_q == tpsr_pkg::TPSR_ST_IDLE) begin
         align_req_q <= 1'b0;
      end
   end

   // full packet due: after reset, each second, after alignment; set wins
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         full_q <= 1'b1;
      end else if (full_tick || state_q == tpsr_pkg::TPSR_ST_ASTAT) begin
         full_q <= 1'b1;
      end else if (start_pkt) begin
         full_q <= 1'b0;
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         state_q      <= tpsr_pkg::TPSR_ST_GREET;
         o_tx_valid   <= 1'b0;
         o_tx_data    <= 8'h00;
         greet_q      <= 4'h0;
         greet_done_q <= 1'b0;
         pkt_q        <= '0;
         prev_q       <= '0;
         idx_q        <= 3'h0;
         reported_q   <= 1'b0;
         lift_q       <= 1'b0;
         ax_q         <= 12'h000;
         ay_q         <= 12'h000;
         align_fail_q <= 1'b0;
      end else begin
         unique case (state_q)
            tpsr_pkg::TPSR_ST_GREET: begin
               if (!o_tx_valid || tx_acc) begin
                  if (greet_q == `TPSR_GREET_LEN) begin
                     o_tx_valid   <= 1'b0;
                     greet_done_q <= 1'b1;
                     state_q      <= tpsr_pkg::TPSR_ST_IDLE;
                  end else begin
                     o_tx_valid <= 1'b1;
                     o_tx_data  <= greet_char(greet_q);
                     greet_q    <= greet_q + 4'h1;
                  end
               end
            end
            tpsr_pkg::TPSR_ST_IDLE: begin
               if (align_req_q) begin
                  state_q <= tpsr_pkg::TPSR_ST_ALIGN1;
               end else if (start_pkt) begin
                  pkt_q      <= pif.bytes;
                  prev_q     <= pif.bytes;
                  idx_q      <= (full_q || !comp_en_q) ? 3'h0 : pif.first_diff;
                  o_tx_valid <= 1'b1;
                  o_tx_data  <= (full_q || !comp_en_q) ? pif.bytes[0] : pif.bytes[pif.first_diff];
                  reported_q <= touched_q;
                  lift_q     <= send_lift;
                  state_q    <= tpsr_pkg::TPSR_ST_SEND;
               end
            end
            // bytes in order, last carries top bit
            tpsr_pkg::TPSR_ST_SEND: begin
               if (tx_acc) begin
                  if (idx_q == `TPSR_LAST_IDX) begin
                     o_tx_valid <= 1'b0;
                     state_q    <= tpsr_pkg::TPSR_ST_IDLE;
                  end else begin
                     o_tx_data <= pkt_q[idx_q + 3'h1];
                     idx_q     <= idx_q + 3'h1;
                  end
               end
            end
            tpsr_pkg::TPSR_ST_ALIGN1: begin
               if (hold_tick) begin
                  ax_q       <= x_q;
                  ay_q       <= y_q;
                  o_tx_valid <= 1'b1;
                  o_tx_data  <= `TPSR_STAT_FIRST;
                  state_q    <= tpsr_pkg::TPSR_ST_ALIGN2;
               end
            end
            tpsr_pkg::TPSR_ST_ALIGN2: begin
               if (tx_acc) begin
                  o_tx_valid <= 1'b0;
               end
               if (hold_tick) begin
                  o_tx_valid   <= 1'b1;
                  align_fail_q <= (dx < MIN_SEP) && (dy < MIN_SEP);
                  o_tx_data    <= ((dx < MIN_SEP) && (dy < MIN_SEP)) ? `TPSR_STAT_FAIL : `TPSR_STAT_DONE;
                  state_q      <= tpsr_pkg::TPSR_ST_ASTAT;
               end
            end
            tpsr_pkg::TPSR_ST_ASTAT: begin
               if (tx_acc) begin
                  o_tx_valid <= 1'b0;
                  reported_q <= 1'b0;
                  state_q    <= tpsr_pkg::TPSR_ST_IDLE;
               end
            end
            default: begin
               o_tx_valid <= 1'b0;
               state_q    <= tpsr_pkg::TPSR_ST_IDLE;
            end
         endcase
      end
   end

   // avalon slave: one wait cycle, then the answer
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata    <= 32'h0000_0000;
      end else if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
         o_avs_waitrequest <= 1'b0;
         unique case (i_avs_address)
            `TPSR_REG_CTRL:   o_avs_readdata <= {30'h0, comp_en_q, o_baud_19200};
            `TPSR_REG_STATUS: o_avs_readdata <= {24'h0, align_fail_q, full_q, suspend_q, greet_done_q,
                                                 touched_q, state_q};
            `TPSR_REG_POINT:  o_avs_readdata <= {z_q, 4'h0, y_q, x_q[11:4]} ^ {24'h0, x_q[3:0], 4'h0};
            default:          o_avs_readdata <= 32'h0000_0000;
         endcase
      end else begin
         o_avs_waitrequest <= 1'b1;
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_baud_19200 <= 1'(`TPSR_CTRL_RESET >> `TPSR_CTRL_BAUD_BIT);
         comp_en_q    <= 1'(`TPSR_CTRL_RESET >> `TPSR_CTRL_COMP_BIT);
      end else if (i_avs_write && !o_avs_waitrequest && i_avs_address == `TPSR_REG_CTRL) begin
         o_baud_19200 <= i_avs_writedata[`TPSR_CTRL_BAUD_BIT];
         comp_en_q    <= i_avs_writedata[`TPSR_CTRL_COMP_BIT];
      end
   end

   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_resetn);

   AST_GREET_FIRST: assert property (state_q == tpsr_pkg::TPSR_ST_SEND |-> greet_done_q)
      else $error("packet sent before greeting");
   AST_MARK_LAST: assert property (state_q == tpsr_pkg::TPSR_ST_SEND |-> o_tx_data[7] == (idx_q == 3'h4))
      else $error("top bit on wrong packet byte");
   AST_RES_ZERO: assert property (state_q == tpsr_pkg::TPSR_ST_SEND && idx_q == 3'h0 |-> !o_tx_data[5])
      else $error("reserved bit not zero");
   AST_LIFT_Z: assert property (state_q == tpsr_pkg::TPSR_ST_SEND && idx_q == 3'h4 && lift_q
                                |-> o_tx_data[5:0] == 6'h00)
      else $error("lift packet has pressure");
   AST_FULL_START: assert property (start_pkt && full_q |=> idx_q == 3'h0 && o_tx_data == pkt_q[0])
      else $error("full packet started late");
   AST_SUSPEND: assert property (rx_any |=> suspend_q && !start_pkt)
      else $error("rx byte did not suspend");
   sequence s_k_in_idle;
      rx_any && i_rx_data == 8'h4B && state_q == tpsr_pkg::TPSR_ST_IDLE && !start_pkt;
   endsequence
   AST_ALIGN_ENTER: assert property (s_k_in_idle |=> ##1 state_q == tpsr_pkg::TPSR_ST_ALIGN1)
      else $error("alignment not entered");
   AST_ASTAT_BYTE: assert property (state_q == tpsr_pkg::TPSR_ST_ASTAT |-> o_tx_valid
                                    && (o_tx_data == 8'hC0 || o_tx_data == 8'hC2))
      else $error("bad alignment status");
   AST_FIRST_TGT: assert property ($rose(state_q == tpsr_pkg::TPSR_ST_ALIGN2) |-> o_tx_data == 8'hC1)
      else $error("first target status wrong");
endmodule : tpsr_top

// *** testbench/tpsr_host_model.sv ***
// tpsr_host_model: host serial port and driver, taking tx bytes and rebuilding packets
// assumes the uart bit engine is abstracted to a byte valid/ready stream for tx and one-cycle valid pulses for rx
`timescale 1ns/100ps
module tpsr_host_model (
   input  wire logic       i_clock,
   input  wire logic       i_resetn,
   input  wire logic       i_tx_valid,
   input  wire logic [7:0] i_tx_data,
   output logic            o_tx_ready,
   output logic            o_rx_valid,
   output logic      [7:0] o_rx_data
);
   integer      seed;
   logic [7:0]  raw_q[$];
   logic [7:0]  stat_q[$];
   logic [39:0] pkt_q[$];
   int          len_q[$];
   logic [39:0] last_pkt;
   logic [31:0] hist;
   int          cnt;
   bit          have_pkt;
   initial begin
      seed = 32'h8A678CE7;
      o_tx_ready = 1'b0;
      o_rx_valid = 1'b0;
      o_rx_data = 8'h00;
   end
   task automatic send(input logic [7:0] b);
      @(posedge i_clock);
      o_rx_valid <= 1'b1;
      o_rx_data <= b;
      @(posedge i_clock);
      o_rx_valid <= 1'b0;
      // idle line shows no stale byte
      o_rx_data <= ~b;
   endtask : send
   task automatic take(input logic [7:0] b);
      logic [39:0] nxt;
      int          k;
      raw_q.push_back(b);
      if (b[7] && b[6]) begin
         stat_q.push_back(b);
         cnt = 0;
      end else if (b[7]) begin
         if (have_pkt || cnt >= 4) begin
            nxt = last_pkt;
            for (k = 0; k < ((cnt > 4) ? 4 : cnt); k++) nxt[8*(k+1)+:8] = hist[8*k+:8];
            nxt[7:0] = b;
            last_pkt = nxt;
            have_pkt = 1'b1;
            pkt_q.push_back(nxt);
            len_q.push_back(((cnt > 4) ? 4 : cnt) + 1);
         end
         cnt = 0;
      end else begin
         hist = {hist[23:0], b};
         cnt++;
      end
   endtask : take
   always @(posedge i_clock) begin
      // random stalls, like a slow uart
      o_tx_ready <= ($random(seed) & 3) != 0;
      if (!i_resetn) begin
         cnt = 0;
         have_pkt = 1'b0;
      end else if (i_tx_valid && o_tx_ready) begin
         take(i_tx_data);
      end
   end
endmodule : tpsr_host_model

// *** testbench/tb_touch_packet_serial_reporter.sv ***
// tb_touch_packet_serial_reporter: self-checking bench of the touch report framer
// assumes the host model stands in for the uart and the serial driver
`timescale 1ns/100ps
module tb_touch_packet_serial_reporter;
   localparam int unsigned PKT  = 50;
   localparam int unsigned SUSP = 300;
   localparam int unsigned HOLD = 40;
   logic        i_clock, i_resetn, i_avs_read, i_avs_write, o_avs_waitrequest;
   logic [3:0]  i_avs_address;
   logic [31:0] i_avs_writedata, o_avs_readdata, rd;
   logic        i_sample_valid, i_touched, i_rx_valid, o_tx_valid, i_tx_ready, o_baud_19200;
   logic [11:0] i_x, i_y;
   logic [7:0]  i_z, i_rx_data, o_tx_data;
   logic [2:0]  scnt;
   integer      seed;
   int          fail_count, comparisons, n, nf, t;
   string       greet;
   tpsr_top #(.PKT_CYCLES(PKT), .FULL_CYCLES(2000), .SUSPEND_CYCLES(SUSP), .HOLD_CYCLES(HOLD)) dut (
      .i_clock, .i_resetn, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_readdata,
      .o_avs_waitrequest, .i_sample_valid, .i_touched, .i_x, .i_y, .i_z, .i_rx_valid, .i_rx_data,
      .o_tx_valid, .o_tx_data, .i_tx_ready, .o_baud_19200);
   tpsr_host_model host (.i_clock, .i_resetn, .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data),
      .o_tx_ready(i_tx_ready), .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data));
   task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic tally_and_finish();
      if (fail_count == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish
   task automatic hang(input string nm);
      chk(nm, 40'h0, 40'h1);
      tally_and_finish();
   endtask : hang
   task automatic avs(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      @(posedge i_clock);
      i_avs_read <= !w;
      i_avs_write <= w;
      i_avs_address <= a;
      i_avs_writedata <= d;
      for (k = 0; k < 64; k++) begin
         @(posedge i_clock);
         if (o_avs_waitrequest === 1'b0) break;
      end
      if (k == 64) hang("waitrequest");
      rd = o_avs_readdata;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
   endtask : avs
   task automatic set_pt(input logic tc, input logic [11:0] x, input logic [11:0] y, input logic [7:0] z);
      @(posedge i_clock);
      i_touched <= tc;
      i_x <= x;
      i_y <= y;
      i_z <= z;
   endtask : set_pt
   task automatic wait_q(input bit st, output int c);
      for (c = 0; c < 3000; c++) begin
         @(posedge i_clock);
         if ((st ? host.stat_q.size() : host.pkt_q.size()) > 0) break;
      end
      if (c == 3000) hang("wait");
   endtask : wait_q
   // expected five bytes of a touched report, first byte in the top bits
   function automatic logic [39:0] mk(logic [11:0] x, logic [11:0] y, logic [7:0] z);
      return {3'b000, y[11:7], 1'b0, z[7:6], x[11:7], 1'b0, y[6:0], 1'b0, x[6:0], 2'b10, z[5:0]};
   endfunction : mk
   task automatic run_pt(input logic [11:0] x, input logic [11:0] y, input logic [7:0] z, input int win);
      logic [39:0] p;
      set_pt(1'b1, x, y, z);
      // settle first so no report of the old point is judged
      repeat (3 * PKT) @(posedge i_clock);
      host.pkt_q.delete();
      host.len_q.delete();
      repeat (win) @(posedge i_clock);
      n = host.pkt_q.size();
      nf = 0;
      while (host.pkt_q.size() > 0) begin
         p = host.pkt_q.pop_front();
         if (host.len_q.pop_front() == 5) nf++;
         chk("packet", p, mk(x, y, z));
      end
   endtask : run_pt
   task automatic align(input logic [11:0] a, input logic [11:0] b, input logic [7:0] st);
      set_pt(1'b1, a, a, 8'h80);
      host.stat_q.delete();
      host.send(8'h4B);
      wait_q(1'b1, t);
      chk("hold time", 40'(t >= HOLD - 4), 40'h1);
      chk("status 1", 40'(host.stat_q.pop_front()), 40'hC1);
      host.pkt_q.delete();
      set_pt(1'b1, b, b, 8'h80);
      wait_q(1'b1, t);
      chk("halted", 40'(host.pkt_q.size()), 40'h0);
      chk("status 2", 40'(host.stat_q.pop_front()), 40'(st));
      host.len_q.delete();
      wait_q(1'b0, t);
      chk("first after", 40'(host.len_q[0]), 40'h5);
   endtask : align
   initial begin
      i_clock = 1'b0;
      forever #2 i_clock = ~i_clock;
   end
   always @(posedge i_clock) begin
      scnt <= scnt + 3'h1;
      i_sample_valid <= (scnt == 3'h0);
   end
   initial begin
      fail_count = 0;
      comparisons = 0;
      seed = 32'h8A678CE7;
      greet = "Hello PnP";
      scnt = 3'h0;
      i_resetn = 1'b0;
      i_avs_read = 1'b0;
      i_avs_write = 1'b0;
      i_avs_address = 4'h0;
      i_avs_writedata = 32'h0;
      i_sample_valid = 1'b0;
      i_touched = 1'b0;
      i_x = 12'h0;
      i_y = 12'h0;
      i_z = 8'h00;
      repeat (6) @(posedge i_clock);
      i_resetn <= 1'b1;
      for (t = 0; t < 500 && host.raw_q.size() < 9; t++) @(posedge i_clock);
      if (t == 500) hang("greeting");
      for (t = 0; t < 9; t++) chk("greeting", 40'(host.raw_q[t]), 40'(greet[t]));
      chk("baud", 40'(o_baud_19200), 40'h0);
      avs(1'b1, 4'hC, 32'hFFFFFFFF);
      avs(1'b0, 4'hC, 32'h0);
      chk("unmapped", 40'(rd), 40'h0);
      avs(1'b0, 4'h0, 32'h0);
      chk("ctrl", 40'(rd), 40'h2);
      set_pt(1'b1, 12'h123, 12'h456, 8'h9A);
      wait_q(1'b0, t);
      chk("first len", 40'(host.len_q[0]), 40'h5);
      // greeting text fills the host history, so only the content shows a short first packet
      chk("first pkt", host.pkt_q[0], mk(12'h123, 12'h456, 8'h9A));
      repeat (3) begin
         run_pt(12'($random(seed)), 12'($random(seed)), 8'($random(seed)) | 8'h01, 1000);
         chk("rate", 40'(n >= 19 && n <= 21), 40'h1);
      end
      run_pt(12'h7FF, 12'h800, 8'hFF, 2100);
      chk("full each period", 40'(nf >= 1), 40'h1);
      avs(1'b1, 4'h0, 32'h1);
      @(negedge i_clock);
      chk("baud", 40'(o_baud_19200), 40'h1);
      run_pt(12'h0AA, 12'h055, 8'h40, 500);
      chk("full only", 40'(nf), 40'(n));
      avs(1'b1, 4'h0, 32'h3);
      host.send(8'h41);
      repeat (30) @(posedge i_clock);
      host.pkt_q.delete();
      repeat (SUSP - 60) @(posedge i_clock);
      chk("suspended", 40'(host.pkt_q.size()), 40'h0);
      repeat (200) @(posedge i_clock);
      chk("resumed", 40'(host.pkt_q.size() > 0), 40'h1);
      set_pt(1'b0, 12'h0, 12'h0, 8'h00);
      repeat (6 * PKT) @(posedge i_clock);
      nf = 0;
      foreach (host.pkt_q[k]) nf += int'(host.pkt_q[k][38]);
      chk("lift count", 40'(nf), 40'h1);
      chk("lift pkt", host.pkt_q[$] & 40'hE0E00000FF, 40'h4000000080);
      align(12'h100, 12'hE00, 8'hC2);
      align(12'h300, 12'h300, 8'hC0);
      tally_and_finish();
   end
endmodule : tb_touch_packet_serial_reporter
